/* debug_link_handshake_abort_tb.sv */
// self-checking bench for the handshake and abort block
`timescale 1ns/1ps
`default_nettype none
module debug_link_handshake_abort_tb;
	typedef struct {
		dlh_pkg::dlh_cmd_e k;
		int ev;
		logic ack;
		logic hs;
	} dlh_row_s;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic wire_lvl, pin_out, pin_oe_n, cmd_valid = 1'b0;
	dlh_pkg::dlh_cmd_e cmd_kind = dlh_pkg::DLH_CMD_OTHER;
	logic bus_done = 1'b0, fw_busy = 1'b0, hold_low = 1'b0;
	logic enter = 1'b0, leave = 1'b0;
	logic hs_enabled, ack_active, sync_active, cmd_cancel, cmd_start;
	logic [7:0] low_len, n_pulses, p0;
	int errors = 0, n_compared = 0, t = 0, t0, n_cancel = 0, n_start = 0;
	int n_sync = 0, c0, i, j;
	dlh_row_s rows[10] = '{
		'{dlh_pkg::DLH_CMD_HS_ON, 0, 1, 1}, '{dlh_pkg::DLH_CMD_READ, 1, 1, 1},
		'{dlh_pkg::DLH_CMD_WRITE, 1, 1, 1}, '{dlh_pkg::DLH_CMD_HALT, 2, 1, 1},
		'{dlh_pkg::DLH_CMD_RESUME, 3, 1, 1}, '{dlh_pkg::DLH_CMD_STEP, 2, 1, 1},
		'{dlh_pkg::DLH_CMD_RUN_TO_HALT, 2, 1, 1},
		'{dlh_pkg::DLH_CMD_OTHER, 0, 0, 1}, '{dlh_pkg::DLH_CMD_HS_OFF, 0, 0, 0},
		'{dlh_pkg::DLH_CMD_READ, 1, 0, 0}};
	dlh_pkg::dlh_cmd_e ab_k[4] = '{dlh_pkg::DLH_CMD_HALT,
		dlh_pkg::DLH_CMD_RESUME, dlh_pkg::DLH_CMD_STEP, dlh_pkg::DLH_CMD_READ};
	logic ab_c[4] = '{1, 0, 0, 0};

	dlh_core i_dlh_core (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
		.pin_in(wire_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .bus_done(bus_done),
		.fw_busy(fw_busy), .cpu_enter_software_breakpoint_instr(enter), .cpu_leave_software_breakpoint_instr(leave),
		.hs_enabled(hs_enabled), .ack_active(ack_active),
		.sync_active(sync_active), .cmd_cancel(cmd_cancel),
		.cmd_start(cmd_start));
	dlh_probe i_dlh_probe (.core_clk(core_clk), .hold_low(hold_low),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .wire_lvl(wire_lvl),
		.low_len(low_len), .n_pulses(n_pulses));

	// 125 MHz clock
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	// counts of the one-cycle pulses and reply cycles
	always @(posedge core_clk) begin
		if (cmd_cancel === 1'b1) n_cancel++;
		if (cmd_start === 1'b1) n_start++;
		if (sync_active === 1'b1) n_sync++;
	end

	task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			t++;
		end
	endtask
	task automatic send(dlh_pkg::dlh_cmd_e k);
		cmd_valid = 1'b1;
		cmd_kind = k;
		tick(1);
		t0 = t;
		cmd_valid = 1'b0;
	endtask
	task automatic event_pulse(int ev);
		bus_done = (ev == 1);
		enter = (ev == 2);
		leave = (ev == 3);
		tick(1);
		{bus_done, enter, leave} = 3'h0;
	endtask
	task automatic abort(int n);
		hold_low = 1'b1;
		tick(n);
		hold_low = 1'b0;
	endtask

	// watchdog
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		tick(12);
		check("oe_n_in_reset", 8'(pin_oe_n), 8'h01);
		reset = 1'b0;
		tick(1);
		check("hs_after_reset", 8'(hs_enabled), 8'h00);
		foreach (rows[r]) begin
			p0 = n_pulses;
			send(rows[r].k);
			tick(3);
			event_pulse(rows[r].ev);
			for (i = 0; i < 100 && ack_active !== 1'b1; i++)
				tick(1);
			check("ack_given", 8'(ack_active), 8'(rows[r].ack));
			if (rows[r].ack)
				check("ack_not_early", 8'(t - t0 >= 32), 8'h01);
			tick(20);
			check("ack_count", n_pulses - p0, 8'(rows[r].ack));
			if (rows[r].ack)
				check("ack_low_len", low_len, 8'h10);
			check("hs_flag", 8'(hs_enabled), 8'(rows[r].hs));
		end
		send(dlh_pkg::DLH_CMD_HS_ON);
		tick(60);
		// long abort: protected kinds and busy firmware keep the command
		for (j = 0; j < 4; j++) begin
			fw_busy = (j == 3);
			send(ab_k[j]);
			tick(2);
			c0 = n_cancel;
			p0 = n_pulses;
			abort(132);
			tick(180);
			fw_busy = 1'b0;
			check("cancel", 8'(n_cancel - c0), 8'(ab_c[j]));
			check("reply_only", n_pulses - p0, 8'h01);
			check("reply_len", low_len, 8'h80);
		end
		check("sync_seen", 8'(n_sync > 128), 8'h01);
		c0 = n_start;
		abort(5);
		tick(10);
		check("new_cmd_start", 8'(n_start - c0), 8'h01);
		// short abort cancels without a reply
		send(dlh_pkg::DLH_CMD_HALT);
		tick(2);
		c0 = n_cancel;
		p0 = n_pulses;
		abort(6);
		tick(10);
		event_pulse(2);
		tick(60);
		check("short_cancel", 8'(n_cancel - c0), 8'h01);
		check("short_no_pulse", n_pulses - p0, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire

/* dlh_core.sv */
// acknowledge handshake and abort logic of the single wire debug port
`timescale 1ns/1ps
`default_nettype none
module dlh_core (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	input wire logic cmd_valid,
	input wire dlh_pkg::dlh_cmd_e cmd_kind,
	input wire logic bus_done,
	input wire logic fw_busy,
	input wire logic cpu_enter_software_breakpoint_instr,
	input wire logic cpu_leave_software_breakpoint_instr,
	output logic hs_enabled,
	output logic ack_active,
	output logic sync_active,
	output logic cmd_cancel,
	output logic cmd_start
);
	// event that completes the pending command, per kind
	function automatic logic ack_event(input dlh_pkg::dlh_cmd_e k,
		input logic bd, input logic en, input logic lv);
		case (k)
			dlh_pkg::DLH_CMD_READ: ack_event = bd;
			dlh_pkg::DLH_CMD_WRITE: ack_event = bd;
			dlh_pkg::DLH_CMD_HS_ON: ack_event = 1'b1;
			dlh_pkg::DLH_CMD_HALT: ack_event = en;
			dlh_pkg::DLH_CMD_RESUME: ack_event = lv;
			dlh_pkg::DLH_CMD_RUN_TO_HALT: ack_event = en;
			dlh_pkg::DLH_CMD_STEP: ack_event = en;
			default: ack_event = 1'b0;
		endcase
	endfunction

	logic sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_next;
	logic [1:0] mask_reg;
	logic [7:0] low_cnt_reg, since_reg, cnt_reg;
	logic sync_seen_reg, hs_reg, pend_reg, done_reg, arm_reg;
	dlh_pkg::dlh_cmd_e kind_reg;
	dlh_pkg::dlh_drv_e drv_reg, drv_next;
	logic [7:0] cnt_next;
	logic host_ok, host_fall, host_rise, sync_hit, start_sync;
	logic abort, keep_cmd, launch, evt, is_rw, protect, acked_kind;

	// pin synchroniser, level accepted once second and third agree
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			sync3_reg <= 1'b1;
			lvl_reg <= 1'b1;
		end else if (clk_en) begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			lvl_reg <= lvl_next;
		end
	end

	// host edges, ignored while we drive and while our echo settles
	assign lvl_next = (sync2_reg == sync3_reg) ? sync3_reg : lvl_reg;
	assign host_ok = (drv_reg == dlh_pkg::DLH_DRV_IDLE) && (mask_reg == 2'h0);
	assign host_fall = host_ok && lvl_reg && !lvl_next;
	assign host_rise = host_ok && !lvl_reg && lvl_next;
	assign sync_hit = host_ok && !lvl_next && !sync_seen_reg &&
		(low_cnt_reg == dlh_pkg::DLH_SYNC_DETECT_CYC - 8'h01);
	assign start_sync = sync_seen_reg && host_rise;

	// abort decode: long pulse at detection, short one at its falling edge
	assign abort = sync_hit || (host_fall && pend_reg);
	assign is_rw = (kind_reg == dlh_pkg::DLH_CMD_READ) ||
		(kind_reg == dlh_pkg::DLH_CMD_WRITE);
	assign protect = (kind_reg == dlh_pkg::DLH_CMD_RESUME) ||
		(kind_reg == dlh_pkg::DLH_CMD_RUN_TO_HALT) ||
		(kind_reg == dlh_pkg::DLH_CMD_STEP);
	assign keep_cmd = protect || (is_rw && fw_busy);
	assign evt = ack_event(kind_reg, bus_done, cpu_enter_software_breakpoint_instr,
		cpu_leave_software_breakpoint_instr);
	assign acked_kind = (cmd_kind != dlh_pkg::DLH_CMD_OTHER) &&
		(cmd_kind != dlh_pkg::DLH_CMD_HS_OFF);
	// ack waits for completion and minimum gap; no check of the wire
	assign launch = pend_reg && done_reg && !sync_seen_reg &&
		(since_reg >= dlh_pkg::DLH_ACK_MIN_DELAY_CYC) &&
		(drv_reg == dlh_pkg::DLH_DRV_IDLE);

	// low time counter and timing reference request flag
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			low_cnt_reg <= 8'h00;
			sync_seen_reg <= 1'b0;
		end else if (clk_en) begin
			if (!host_ok || lvl_next)
				low_cnt_reg <= 8'h00;
			else if (low_cnt_reg != dlh_pkg::DLH_SYNC_DETECT_CYC)
				low_cnt_reg <= low_cnt_reg + 8'h01;
			if (sync_hit)
				sync_seen_reg <= 1'b1;
			else if (start_sync)
				sync_seen_reg <= 1'b0;
		end
	end

	// handshake flag, starts disabled
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			hs_reg <= 1'b0;
		else if (clk_en && cmd_valid) begin
			if (cmd_kind == dlh_pkg::DLH_CMD_HS_ON)
				hs_reg <= 1'b1;
			else if (cmd_kind == dlh_pkg::DLH_CMD_HS_OFF)
				hs_reg <= 1'b0;
		end
	end

	// pending acknowledge tracking; a new command outranks an abort
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pend_reg <= 1'b0;
			done_reg <= 1'b0;
			kind_reg <= dlh_pkg::DLH_CMD_OTHER;
			since_reg <= 8'h00;
		end else if (clk_en) begin
			if (cmd_valid) begin
				kind_reg <= cmd_kind;
				since_reg <= 8'h00;
				done_reg <= 1'b0;
				pend_reg <= acked_kind && (hs_reg ||
					cmd_kind == dlh_pkg::DLH_CMD_HS_ON);
			end else begin
				if (since_reg != dlh_pkg::DLH_ACK_MIN_DELAY_CYC)
					since_reg <= since_reg + 8'h01;
				if (abort || launch) begin
					pend_reg <= 1'b0;
					done_reg <= 1'b0;
				end else if (pend_reg && evt)
					done_reg <= 1'b1;
			end
		end
	end

	// pin driver sequencing for reference reply and ack
	always_comb begin
		drv_next = drv_reg;
		cnt_next = cnt_reg + 8'h01;
		case (drv_reg)
			dlh_pkg::DLH_DRV_IDLE: begin
				cnt_next = 8'h00;
				if (start_sync)
					drv_next = dlh_pkg::DLH_DRV_GAP;
				else if (launch)
					drv_next = dlh_pkg::DLH_DRV_ACK_LOW;
			end
			dlh_pkg::DLH_DRV_GAP: begin
				if (cnt_reg == dlh_pkg::DLH_SYNC_GAP_CYC - 8'h01) begin
					drv_next = dlh_pkg::DLH_DRV_SYNC_LOW;
					cnt_next = 8'h00;
				end
			end
			dlh_pkg::DLH_DRV_SYNC_LOW: begin
				if (cnt_reg == dlh_pkg::DLH_SYNC_LOW_CYC - 8'h01)
					drv_next = dlh_pkg::DLH_DRV_SPEEDUP;
			end
			dlh_pkg::DLH_DRV_ACK_LOW: begin
				if (cnt_reg == dlh_pkg::DLH_ACK_LOW_CYC - 8'h01)
					drv_next = dlh_pkg::DLH_DRV_SPEEDUP;
			end
			dlh_pkg::DLH_DRV_SPEEDUP: begin
				drv_next = dlh_pkg::DLH_DRV_IDLE;
				cnt_next = 8'h00;
			end
			default: begin
				drv_next = dlh_pkg::DLH_DRV_IDLE;
				cnt_next = 8'h00;
			end
		endcase
	end

	// driver state and echo mask
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			drv_reg <= dlh_pkg::DLH_DRV_IDLE;
			cnt_reg <= 8'h00;
			mask_reg <= 2'h0;
		end else if (clk_en) begin
			drv_reg <= drv_next;
			cnt_reg <= cnt_next;
			if (drv_reg == dlh_pkg::DLH_DRV_SPEEDUP)
				mask_reg <= dlh_pkg::DLH_ECHO_MASK_CYC;
			else if (mask_reg != 2'h0)
				mask_reg <= mask_reg - 2'h1;
		end
	end

	// registered outputs; pin drive and ack flag taken from the next driver state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
			ack_active <= 1'b0;
			sync_active <= 1'b0;
			cmd_cancel <= 1'b0;
			cmd_start <= 1'b0;
			arm_reg <= 1'b0;
			hs_enabled <= 1'b0;
		end else if (clk_en) begin
			pin_out <= (drv_next == dlh_pkg::DLH_DRV_SPEEDUP);
			pin_oe_n <= (drv_next == dlh_pkg::DLH_DRV_IDLE) ||
				(drv_next == dlh_pkg::DLH_DRV_GAP);
			ack_active <= (drv_next == dlh_pkg::DLH_DRV_ACK_LOW);
			sync_active <= sync_hit || sync_seen_reg ||
				(drv_next == dlh_pkg::DLH_DRV_GAP) ||
				(drv_next == dlh_pkg::DLH_DRV_SYNC_LOW);
			cmd_cancel <= abort && pend_reg && !keep_cmd;
			cmd_start <= host_fall && arm_reg && !abort;
			if (abort)
				arm_reg <= 1'b1;
			else if (host_fall)
				arm_reg <= 1'b0;
			hs_enabled <= (cmd_valid && cmd_kind == dlh_pkg::DLH_CMD_HS_ON) ||
				(hs_reg && !(cmd_valid && cmd_kind == dlh_pkg::DLH_CMD_HS_OFF));
		end
	end

	// own count of cycles since the last command, for the ack gap check
	logic [7:0] gap_chk_reg;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			gap_chk_reg <= 8'h00;
		else if (clk_en) begin
			if (cmd_valid)
				gap_chk_reg <= 8'h00;
			else if (gap_chk_reg != 8'hff)
				gap_chk_reg <= gap_chk_reg + 8'h01;
		end
	end

	default clocking dlh_cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	property p_hs_on_sets;
		clk_en && cmd_valid && cmd_kind == dlh_pkg::DLH_CMD_HS_ON |=>
			hs_reg && hs_enabled;
	endproperty
	a_hs_on_sets: assert property (p_hs_on_sets)
		else $error("handshake-on did not enable handshake");

	property p_hs_off_clears;
		clk_en && cmd_valid && cmd_kind == dlh_pkg::DLH_CMD_HS_OFF |=>
			!hs_reg && !pend_reg;
	endproperty
	a_hs_off_clears: assert property (p_hs_off_clears)
		else $error("handshake-off left handshake on");

	property p_ack_shape;
		clk_en && drv_reg == dlh_pkg::DLH_DRV_ACK_LOW &&
			cnt_reg == dlh_pkg::DLH_ACK_LOW_CYC - 8'h01 |=>
			drv_reg == dlh_pkg::DLH_DRV_SPEEDUP && pin_out && !pin_oe_n;
	endproperty
	a_ack_shape: assert property (p_ack_shape)
		else $error("ack low phase not sixteen cycles");

	property p_ack_drives_low;
		drv_reg == dlh_pkg::DLH_DRV_ACK_LOW |-> !pin_oe_n && !pin_out;
	endproperty
	a_ack_drives_low: assert property (p_ack_drives_low)
		else $error("pin not driven low during ack");

	property p_ack_min_delay;
		$rose(ack_active) |-> gap_chk_reg > dlh_pkg::DLH_ACK_MIN_DELAY_CYC;
	endproperty
	a_ack_min_delay: assert property (p_ack_min_delay)
		else $error("ack launched before thirty-two cycles");

	property p_sync_shape;
		clk_en && drv_reg == dlh_pkg::DLH_DRV_SYNC_LOW &&
			cnt_reg == dlh_pkg::DLH_SYNC_LOW_CYC - 8'h01 |=>
			drv_reg == dlh_pkg::DLH_DRV_SPEEDUP;
	endproperty
	a_sync_shape: assert property (p_sync_shape)
		else $error("reference reply low phase not 128 cycles");

	property p_sync_reply;
		clk_en && start_sync |=> drv_reg == dlh_pkg::DLH_DRV_GAP;
	endproperty
	a_sync_reply: assert property (p_sync_reply)
		else $error("reference reply not started");

	property p_fw_keep;
		clk_en && abort && is_rw && fw_busy |=> !cmd_cancel && !pend_reg;
	endproperty
	a_fw_keep: assert property (p_fw_keep)
		else $error("busy access cancelled or ack kept");

	property p_protect;
		clk_en && sync_hit && protect |=> !cmd_cancel && !pend_reg;
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected command cancelled");

	property p_halt_ack;
		clk_en && !cmd_valid && !abort && pend_reg && cpu_enter_software_breakpoint_instr &&
			kind_reg == dlh_pkg::DLH_CMD_HALT |=> done_reg;
	endproperty
	a_halt_ack: assert property (p_halt_ack)
		else $error("halt completion not recorded");

	c_ack: cover property (drv_reg == dlh_pkg::DLH_DRV_ACK_LOW);
	c_sync: cover property (drv_reg == dlh_pkg::DLH_DRV_SYNC_LOW);
	c_cancel: cover property (cmd_cancel);
	c_start: cover property (cmd_start);
endmodule
`default_nettype wire

/* dlh_pkg.sv */
// constants and types for the debug link handshake and abort block
package dlh_pkg;
	localparam logic [7:0] DLH_SYNC_DETECT_CYC = 8'h80;
	localparam logic [7:0] DLH_SYNC_GAP_CYC = 8'h10;
	localparam logic [7:0] DLH_SYNC_LOW_CYC = 8'h80;
	localparam logic [7:0] DLH_ACK_LOW_CYC = 8'h10;
	localparam logic [7:0] DLH_ACK_MIN_DELAY_CYC = 8'h20;
	localparam logic [1:0] DLH_ECHO_MASK_CYC = 2'h3;

	typedef enum logic [3:0] {
		DLH_CMD_READ,
		DLH_CMD_WRITE,
		DLH_CMD_HS_ON,
		DLH_CMD_HS_OFF,
		DLH_CMD_HALT,
		DLH_CMD_RESUME,
		DLH_CMD_RUN_TO_HALT,
		DLH_CMD_STEP,
		DLH_CMD_OTHER
	} dlh_cmd_e;

	typedef enum logic [2:0] {
		DLH_DRV_IDLE,
		DLH_DRV_GAP,
		DLH_DRV_SYNC_LOW,
		DLH_DRV_ACK_LOW,
		DLH_DRV_SPEEDUP
	} dlh_drv_e;
endpackage

/* dlh_probe.sv */
// host side probe model on the debug wire
`timescale 1ns/1ps
`default_nettype none
module dlh_probe (
	input wire logic core_clk,
	input wire logic hold_low,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	output logic wire_lvl,
	output logic [7:0] low_len,
	output logic [7:0] n_pulses
);
	logic held_reg = 1'b0;
	logic [7:0] cnt_reg = 8'h00;
	logic [7:0] len_reg = 8'h00;
	logic [7:0] np_reg = 8'h00;
	// host low wins, then host speedup in the cycle after its low,
	// then target drive, else pull-up
	assign wire_lvl = hold_low ? 1'b0 : (held_reg ? 1'b1 :
		(!pin_oe_n ? pin_out : 1'b1));
	assign low_len = len_reg;
	assign n_pulses = np_reg;
	// length and number of target low pulses
	always @(posedge core_clk) begin
		held_reg <= hold_low;
		if (!pin_oe_n && !pin_out)
			cnt_reg <= cnt_reg + 8'h01;
		else if (cnt_reg != 8'h00) begin
			len_reg <= cnt_reg;
			np_reg <= np_reg + 8'h01;
			cnt_reg <= 8'h00;
		end
	end
endmodule
`default_nettype wire
